// >>> hw/slave_io_map_pkg.sv
// Shared constants and types for the slave I/O allocation map.
package slave_io_map_pkg;

    localparam int NODES = 16;
    localparam int WORDS = 8;

    // APB byte addresses.
    localparam logic [7:0] ADDR_OUT_BASE = 8'h00;
    localparam logic [7:0] ADDR_IN_BASE = 8'h20;
    localparam logic [7:0] ADDR_ACT_OUT = 8'h40;
    localparam logic [7:0] ADDR_ACT_IN = 8'h44;
    localparam logic [7:0] ADDR_ERR_OUT = 8'h48;
    localparam logic [7:0] ADDR_ERR_IN = 8'h4c;
    localparam logic [7:0] ADDR_CTRL = 8'h50;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h54;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h58;

    // Image regions are selected by address bits 7:5.
    localparam logic [2:0] REGION_OUT = 3'h0;
    localparam logic [2:0] REGION_IN = 3'h1;

    // Control register fields.
    localparam int CTRL_WIDE_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam logic CTRL_WIDE_RESET = 1'b1;

    // Interrupt status and mask fields.
    localparam int IRQ_WIDTH = 3;
    localparam int IRQ_JOIN_BIT = 0;
    localparam int IRQ_REFUSE_BIT = 1;
    localparam int IRQ_DROP_BIT = 2;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;

    // Byte ownership masks of one node slot.
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_NIBBLE = 8'h0f;
    localparam logic [7:0] MASK_NONE = 8'h00;

    // Slot limits for the narrow (nodes 0 to 7) and wide (0 to 15) maps.
    localparam logic [4:0] LIMIT_NARROW = 5'h08;
    localparam logic [4:0] LIMIT_WIDE = 5'h10;

    typedef enum logic [2:0] {
        KIND_8PT = 3'h0,
        KIND_4PT = 3'h1,
        KIND_16PT = 3'h3,
        KIND_32PT = 3'h2,
        KIND_ANA48 = 3'h6,
        KIND_ANA64 = 3'h7
    } slaveKind_t;

    typedef struct packed {
        logic [3:0] node;
        slaveKind_t kind;
        logic hasOut;
        logic hasIn;
    } joinReq_t;

    typedef struct packed {
        logic [3:0] node;
        logic isOut;
        logic isIn;
    } dropReq_t;

    typedef struct packed {
        logic [3:0] slot;
        logic [7:0] data;
    } inByte_t;

    // Number of node slots a slave of the given kind occupies.
    function automatic logic [4:0] slotCount(input slaveKind_t kind);
        case (kind)
            KIND_8PT: slotCount = 5'h01;
            KIND_4PT: slotCount = 5'h01;
            KIND_16PT: slotCount = 5'h02;
            KIND_32PT: slotCount = 5'h04;
            KIND_ANA48: slotCount = 5'h06;
            KIND_ANA64: slotCount = 5'h08;
            default: slotCount = 5'h01;
        endcase
    endfunction

endpackage

// >>> hw/slave_io_map.sv
// Remote slave I/O image allocator with APB register access and sticky node flags.
`timescale 1ns/100ps

module slave_io_map (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Network side: joining, dropping out and input data
    input wire logic joinStrobe,
    input wire slave_io_map_pkg::joinReq_t joinReq,
    input wire logic dropStrobe,
    input wire slave_io_map_pkg::dropReq_t dropReq,
    input wire logic inStrobe,
    input wire slave_io_map_pkg::inByte_t inByte,
    // Output image towards the output slaves, slot n in bits 8n+7:8n
    output logic [127:0] outImage,
    // Status
    output logic linkStatusLamp,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // APB access phase
    logic access;
    logic writeAcc;
    logic [2:0] region;
    logic [2:0] wordIdx;
    logic aligned;
    logic ctrlWide;
    logic next_ctrlWide;
    logic restart;

    assign access = psel & penable & pready;
    assign writeAcc = access & pwrite;
    assign region = paddr[7:5];
    assign wordIdx = paddr[4:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign restart = writeAcc && aligned && paddr == slave_io_map_pkg::ADDR_CTRL &&
        pwdata[slave_io_map_pkg::CTRL_RESTART_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Join decode: slot range and refusal
    logic [4:0] startSlot;
    logic [4:0] endSlot;
    logic [4:0] limit;
    logic joinOk;
    logic joinBad;
    logic [15:0] claim;
    logic [7:0] claimMask;
    logic nextLamp;

    always_comb begin
        if (slave_io_map_pkg::slotCount(joinReq.kind) == 5'h01) begin
            startSlot = {1'b0, joinReq.node};
        end else begin
            startSlot = {1'b0, joinReq.node[3:1], 1'b0};
        end
        endSlot = startSlot + slave_io_map_pkg::slotCount(joinReq.kind);
        limit = ctrlWide ? slave_io_map_pkg::LIMIT_WIDE : slave_io_map_pkg::LIMIT_NARROW;
        joinOk = joinStrobe && endSlot <= limit;
        joinBad = joinStrobe && endSlot > limit;
        claimMask = (joinReq.kind == slave_io_map_pkg::KIND_4PT) ?
            slave_io_map_pkg::MASK_NIBBLE : slave_io_map_pkg::MASK_FULL;
        for (int i = 0; i < slave_io_map_pkg::NODES; i++) begin
            claim[i] = joinOk && 5'(i) >= startSlot && 5'(i) < endSlot;
        end
        nextLamp = linkStatusLamp;
        if (restart) begin
            nextLamp = 1'b0;
        end
        if (joinOk) begin
            nextLamp = 1'b1;
        end else if (joinBad) begin
            nextLamp = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            linkStatusLamp <= 1'b0;
        end else begin
            linkStatusLamp <= nextLamp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Image storage, one slot byte per node and direction
    logic [15:0][7:0] outData;
    logic [15:0][7:0] inData;
    logic [15:0][7:0] outMask;
    logic [15:0][7:0] inMask;

    assign outImage = outData;

    generate
        for (genvar s = 0; s < slave_io_map_pkg::NODES; s++) begin : g_slot
            logic [7:0] next_outData;
            logic [7:0] next_inData;
            logic [7:0] next_outMask;
            logic [7:0] next_inMask;
            logic slotWrite;

            // Even slot is the low byte of a word, odd slot the high byte.
            assign slotWrite = writeAcc && aligned && region == slave_io_map_pkg::REGION_OUT &&
                wordIdx == 3'(s / 2);

            always_comb begin
                next_outData = outData[s];
                next_inData = inData[s];
                next_outMask = outMask[s];
                next_inMask = inMask[s];
                if (restart) begin
                    next_outData = 8'h00;
                    next_inData = 8'h00;
                    next_outMask = slave_io_map_pkg::MASK_NONE;
                    next_inMask = slave_io_map_pkg::MASK_NONE;
                end
                if (slotWrite) begin
                    next_outData = pwdata[8*(s%2)+:8] & outMask[s];
                end
                if (inStrobe && inByte.slot == 4'(s)) begin
                    next_inData = inByte.data & inMask[s];
                end
                // A fresh claim clears stale data so unused bits read zero.
                if (claim[s] && joinReq.hasOut) begin
                    next_outMask = claimMask;
                    next_outData = 8'h00;
                end
                if (claim[s] && joinReq.hasIn) begin
                    next_inMask = claimMask;
                    next_inData = 8'h00;
                end
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    outData[s] <= 8'h00;
                    inData[s] <= 8'h00;
                    outMask[s] <= slave_io_map_pkg::MASK_NONE;
                    inMask[s] <= slave_io_map_pkg::MASK_NONE;
                end else begin
                    outData[s] <= next_outData;
                    inData[s] <= next_inData;
                    outMask[s] <= next_outMask;
                    inMask[s] <= next_inMask;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Sticky active and error flags per node
    logic [15:0] activeOut;
    logic [15:0] activeIn;
    logic [15:0] errOut;
    logic [15:0] errIn;
    logic [15:0] next_activeOut;
    logic [15:0] next_activeIn;
    logic [15:0] next_errOut;
    logic [15:0] next_errIn;
    logic [15:0] joinNode;
    logic [15:0] dropNode;

    always_comb begin
        joinNode = joinOk ? (16'h0001 << joinReq.node) : 16'h0000;
        dropNode = dropStrobe ? (16'h0001 << dropReq.node) : 16'h0000;
        next_activeOut = activeOut;
        next_activeIn = activeIn;
        next_errOut = errOut;
        next_errIn = errIn;
        if (restart) begin
            next_activeOut = 16'h0000;
            next_activeIn = 16'h0000;
            next_errOut = 16'h0000;
            next_errIn = 16'h0000;
        end
        // Drop-out leaves the active flag alone; a rejoin clears the error.
        if (joinReq.hasOut) begin
            next_activeOut = next_activeOut | joinNode;
            next_errOut = next_errOut & ~joinNode;
        end
        if (joinReq.hasIn) begin
            next_activeIn = next_activeIn | joinNode;
            next_errIn = next_errIn & ~joinNode;
        end
        if (dropReq.isOut) begin
            next_errOut = next_errOut | dropNode;
        end
        if (dropReq.isIn) begin
            next_errIn = next_errIn | dropNode;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            activeOut <= 16'h0000;
            activeIn <= 16'h0000;
            errOut <= 16'h0000;
            errIn <= 16'h0000;
        end else begin
            activeOut <= next_activeOut;
            activeIn <= next_activeIn;
            errOut <= next_errOut;
            errIn <= next_errIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and interrupts
    logic [slave_io_map_pkg::IRQ_WIDTH-1:0] irqStat;
    logic [slave_io_map_pkg::IRQ_WIDTH-1:0] irqMask;
    logic [slave_io_map_pkg::IRQ_WIDTH-1:0] next_irqStat;
    logic [slave_io_map_pkg::IRQ_WIDTH-1:0] next_irqMask;
    logic [slave_io_map_pkg::IRQ_WIDTH-1:0] events;
    logic next_irq;

    always_comb begin
        events = '0;
        events[slave_io_map_pkg::IRQ_JOIN_BIT] = joinOk;
        events[slave_io_map_pkg::IRQ_REFUSE_BIT] = joinBad;
        events[slave_io_map_pkg::IRQ_DROP_BIT] = dropStrobe;
        next_ctrlWide = ctrlWide;
        next_irqStat = irqStat;
        next_irqMask = irqMask;
        if (writeAcc && aligned) begin
            case (paddr)
                slave_io_map_pkg::ADDR_CTRL: begin
                    next_ctrlWide = pwdata[slave_io_map_pkg::CTRL_WIDE_BIT];
                end
                slave_io_map_pkg::ADDR_IRQ_STAT: begin
                    next_irqStat = irqStat & ~pwdata[slave_io_map_pkg::IRQ_WIDTH-1:0];
                end
                slave_io_map_pkg::ADDR_IRQ_MASK: begin
                    next_irqMask = pwdata[slave_io_map_pkg::IRQ_WIDTH-1:0];
                end
                default: begin
                    next_ctrlWide = ctrlWide;
                end
            endcase
        end
        // A new event in the clearing cycle stays set.
        next_irqStat = next_irqStat | events;
        next_irq = |(next_irqStat & next_irqMask);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrlWide <= slave_io_map_pkg::CTRL_WIDE_RESET;
            irqStat <= '0;
            irqMask <= slave_io_map_pkg::IRQ_MASK_RESET;
            irq <= 1'b0;
        end else begin
            ctrlWide <= next_ctrlWide;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait cycle so read data and ready come from flip-flops
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic hit;

    always_comb begin
        hit = aligned;
        next_prdata = 32'h0000_0000;
        if (region == slave_io_map_pkg::REGION_OUT) begin
            next_prdata = {16'h0000, outData[{wordIdx, 1'b1}], outData[{wordIdx, 1'b0}]};
        end else if (region == slave_io_map_pkg::REGION_IN) begin
            next_prdata = {16'h0000, inData[{wordIdx, 1'b1}], inData[{wordIdx, 1'b0}]};
        end else begin
            case (paddr)
                slave_io_map_pkg::ADDR_ACT_OUT: next_prdata = {16'h0000, activeOut};
                slave_io_map_pkg::ADDR_ACT_IN: next_prdata = {16'h0000, activeIn};
                slave_io_map_pkg::ADDR_ERR_OUT: next_prdata = {16'h0000, errOut};
                slave_io_map_pkg::ADDR_ERR_IN: next_prdata = {16'h0000, errIn};
                slave_io_map_pkg::ADDR_CTRL: next_prdata = {31'h0000_0000, ctrlWide};
                slave_io_map_pkg::ADDR_IRQ_STAT: next_prdata = {29'h0000_0000, irqStat};
                slave_io_map_pkg::ADDR_IRQ_MASK: next_prdata = {29'h0000_0000, irqMask};
                default: hit = 1'b0;
            endcase
        end
        if (region == slave_io_map_pkg::REGION_IN && pwrite) begin
            hit = 1'b0;
        end
        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && !hit;
        if (!next_pready || pwrite || !hit) begin
            next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

// >>> tb/slave_io_map_asserts.sv
// Port level checker of the slave I/O allocation map.
`timescale 1ns/100ps

module slave_io_map_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Network side and status
    input wire logic joinStrobe,
    input wire slave_io_map_pkg::joinReq_t joinReq,
    input wire logic [127:0] outImage,
    input wire logic linkStatusLamp
);
    ////////////////////////////////////////////////////////////////////////////////
    logic wide;
    logic next_wide;
    logic commit;
    logic joinOk;
    logic [4:0] joinStart;
    logic [4:0] joinCount;

    assign commit = psel && penable && pready;
    // The map width follows ctrl writes, so the refusal limit is known here too.
    always_comb next_wide = (commit && pwrite && paddr == slave_io_map_pkg::ADDR_CTRL) ?
        pwdata[slave_io_map_pkg::CTRL_WIDE_BIT] : wide;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) wide <= slave_io_map_pkg::CTRL_WIDE_RESET;
        else wide <= next_wide;
    end
    assign joinCount = (joinReq.kind == slave_io_map_pkg::KIND_16PT) ? 5'h02 :
        (joinReq.kind == slave_io_map_pkg::KIND_32PT) ? 5'h04 :
        (joinReq.kind == slave_io_map_pkg::KIND_ANA48) ? 5'h06 :
        (joinReq.kind == slave_io_map_pkg::KIND_ANA64) ? 5'h08 : 5'h01;
    assign joinStart = {1'b0, joinReq.node[3:1], joinReq.node[0] && joinCount == 5'h01};
    assign joinOk = joinStart + joinCount <=
        (wide ? slave_io_map_pkg::LIMIT_WIDE : slave_io_map_pkg::LIMIT_NARROW);

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbAccess;
        psel && penable && !pready;
    endsequence

    AST_PREADY_WAIT: assert property (apbSetup ##1 apbAccess |=> pready)
        else $error("pready not given one cycle into the access phase");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data shown outside a completing transfer");
    AST_IN_WRITE_REFUSED: assert property (commit && pwrite &&
        paddr[7:5] == slave_io_map_pkg::REGION_IN |-> pslverr)
        else $error("write to the input image not refused");
    AST_ACCEPT_LAMP: assert property (joinStrobe && joinOk |=> linkStatusLamp)
        else $error("lamp off after a join that fits");
    AST_REFUSE_LAMP: assert property (joinStrobe && !joinOk |=> !linkStatusLamp)
        else $error("lamp on after a join outside the map");
    AST_RESTART_LAMP: assert property (commit && pwrite && !joinStrobe && paddr ==
        slave_io_map_pkg::ADDR_CTRL && pwdata[slave_io_map_pkg::CTRL_RESTART_BIT]
        |=> !linkStatusLamp)
        else $error("lamp on after restart");
    AST_OUT_CAUSE: assert property ($changed(outImage) |->
        $past(commit && pwrite || joinStrobe))
        else $error("output image changed without a write or join");
endmodule

// >>> tb/slave_net_model.sv
// Behavioural model of the remote slaves: joining, dropping out and sending inputs.
`timescale 1ns/100ps

module slave_net_model (
    // Clock
    input wire logic clk,
    // Towards the allocator
    output logic joinStrobe,
    output slave_io_map_pkg::joinReq_t joinReq,
    output logic dropStrobe,
    output slave_io_map_pkg::dropReq_t dropReq,
    output logic inStrobe,
    output slave_io_map_pkg::inByte_t inByte
);
    // Idle fields show the inverse of the last value, so stale data is never trusted.
    initial begin
        joinStrobe = 1'b0;
        joinReq = '0;
        dropStrobe = 1'b0;
        dropReq = '0;
        inStrobe = 1'b0;
        inByte = '0;
    end
    // Callers never claim slots that overlap in one direction.
    task automatic joinSlave(input logic [3:0] n, input slave_io_map_pkg::slaveKind_t k,
        input logic o, input logic i);
        @(posedge clk);
        joinStrobe <= 1'b1;
        joinReq <= {n, k, o, i};
        @(posedge clk);
        joinStrobe <= 1'b0;
        joinReq <= ~{n, k, o, i};
    endtask
    task automatic dropNode(input logic [3:0] n, input logic o, input logic i);
        @(posedge clk);
        dropStrobe <= 1'b1;
        dropReq <= {n, o, i};
        @(posedge clk);
        dropStrobe <= 1'b0;
        dropReq <= ~{n, o, i};
    endtask
    task automatic sendIn(input logic [3:0] s, input logic [7:0] d);
        @(posedge clk);
        inStrobe <= 1'b1;
        inByte <= {s, d};
        @(posedge clk);
        inStrobe <= 1'b0;
        inByte <= ~{s, d};
    endtask
endmodule

// >>> tb/tb_slave_io_map.sv
// Self-checking bench of the slave I/O allocation map.
`timescale 1ns/100ps

module tb_slave_io_map;
    logic clk;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic joinStrobe;
    slave_io_map_pkg::joinReq_t joinReq;
    logic dropStrobe;
    slave_io_map_pkg::dropReq_t dropReq;
    logic inStrobe;
    slave_io_map_pkg::inByte_t inByte;
    logic [127:0] outImage;
    logic linkStatusLamp;
    logic irq;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 32'hfadf;
    logic [33:0] expQ[$];
    logic [33:0] e;
    logic [7:0] outM[16];
    logic [7:0] inM[16];
    logic [7:0] inB[16];
    logic [15:0] actO = 16'h0;
    logic [15:0] actI = 16'h0;
    logic [127:0] img;
    logic [31:0] d;

    slave_io_map i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .joinStrobe(joinStrobe), .joinReq(joinReq),
        .dropStrobe(dropStrobe), .dropReq(dropReq), .inStrobe(inStrobe), .inByte(inByte),
        .outImage(outImage), .linkStatusLamp(linkStatusLamp), .irq(irq));
    slave_net_model i_net (.clk(clk), .joinStrobe(joinStrobe), .joinReq(joinReq),
        .dropStrobe(dropStrobe), .dropReq(dropReq), .inStrobe(inStrobe), .inByte(inByte));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string nm, input logic [127:0] x, input logic [127:0] g);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Every transfer notes its expected answer; the watcher below compares it.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        input logic [31:0] x, input logic chk, input logic err);
        int n;
        expQ.push_back({chk, err, x});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("pready timeout");
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b1, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0, 1'b0, 1'b0);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #10;
    endtask
    // Join a slave and note the slots and flags it should own.
    task automatic claim(input logic [3:0] n, input slave_io_map_pkg::slaveKind_t k,
        input logic o, input logic i, input logic ok);
        int s;
        int c;
        c = (k == slave_io_map_pkg::KIND_16PT) ? 2 : (k == slave_io_map_pkg::KIND_32PT) ? 4 :
            (k == slave_io_map_pkg::KIND_ANA48) ? 6 : (k == slave_io_map_pkg::KIND_ANA64) ? 8 : 1;
        s = (c == 1) ? n : (n & 14);
        i_net.joinSlave(n, k, o, i);
        #10;
        check("lamp", ok, linkStatusLamp);
        for (int j = s; j < s + c && ok; j++) begin
            if (o) outM[j] = (k == slave_io_map_pkg::KIND_4PT) ? 8'h0f : 8'hff;
            if (i) inM[j] = (k == slave_io_map_pkg::KIND_4PT) ? 8'h0f : 8'hff;
        end
        if (ok) actO[n] = actO[n] | o;
        if (ok) actI[n] = actI[n] | i;
    endtask

    always @(posedge clk) begin
        if (pready === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            check("pslverr", e[32], pslverr);
            if (e[33]) check("prdata", e[31:0], prdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        foreach (outM[j]) {outM[j], inM[j]} = 16'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(slave_io_map_pkg::ADDR_CTRL, 32'h1);
        rd(slave_io_map_pkg::ADDR_ACT_OUT, 32'h0);
        rd(slave_io_map_pkg::ADDR_ACT_IN, 32'h0);
        rd(slave_io_map_pkg::ADDR_IRQ_MASK, 32'h0);
        $display("reset values done");
        claim(4'h2, slave_io_map_pkg::KIND_8PT, 1'b1, 1'b0, 1'b1);
        claim(4'h5, slave_io_map_pkg::KIND_16PT, 1'b1, 1'b0, 1'b1);
        claim(4'h9, slave_io_map_pkg::KIND_32PT, 1'b1, 1'b0, 1'b1);
        claim(4'h3, slave_io_map_pkg::KIND_4PT, 1'b1, 1'b1, 1'b1);
        claim(4'h7, slave_io_map_pkg::KIND_ANA48, 1'b0, 1'b1, 1'b1);
        claim(4'hd, slave_io_map_pkg::KIND_8PT, 1'b1, 1'b1, 1'b1);
        claim(4'he, slave_io_map_pkg::KIND_16PT, 1'b1, 1'b1, 1'b1);
        claim(4'hf, slave_io_map_pkg::KIND_ANA64, 1'b0, 1'b1, 1'b0);
        wr(slave_io_map_pkg::ADDR_CTRL, 32'h0);
        claim(4'h7, slave_io_map_pkg::KIND_32PT, 1'b1, 1'b0, 1'b0);
        wr(slave_io_map_pkg::ADDR_CTRL, 32'h1);
        rd(slave_io_map_pkg::ADDR_ACT_OUT, {16'h0, actO});
        rd(slave_io_map_pkg::ADDR_ACT_IN, {16'h0, actI});
        $display("joins done");
        for (int w = 0; w < 8; w++) begin
            d = $random(seed);
            img[w*16 +: 16] = d[15:0] & {outM[2*w+1], outM[2*w]};
            wr(slave_io_map_pkg::ADDR_OUT_BASE + 8'(w * 4), d);
            rd(slave_io_map_pkg::ADDR_OUT_BASE + 8'(w * 4), {16'h0, img[w*16 +: 16]});
        end
        settle();
        check("outImage", img, outImage);
        for (int s = 0; s < 16; s++) begin
            d = $random(seed);
            inB[s] = d[7:0] & inM[s];
            i_net.sendIn(4'(s), d[7:0]);
        end
        for (int w = 0; w < 8; w++) begin
            rd(slave_io_map_pkg::ADDR_IN_BASE + 8'(w * 4), {16'h0, inB[2*w+1], inB[2*w]});
        end
        $display("images done");
        settle();
        check("irq masked", 1'b0, irq);
        wr(slave_io_map_pkg::ADDR_IRQ_MASK, 32'h4);
        i_net.dropNode(4'h5, 1'b1, 1'b0);
        settle();
        check("irq", 1'b1, irq);
        rd(slave_io_map_pkg::ADDR_ERR_OUT, 32'h20);
        rd(slave_io_map_pkg::ADDR_ERR_IN, 32'h0);
        rd(slave_io_map_pkg::ADDR_ACT_OUT, {16'h0, actO});
        rd(slave_io_map_pkg::ADDR_IRQ_STAT, 32'h7);
        wr(slave_io_map_pkg::ADDR_IRQ_STAT, 32'h7);
        settle();
        check("irq cleared", 1'b0, irq);
        $display("drop done");
        // The lamp must be lit before the restart, or the check below proves nothing.
        claim(4'h0, slave_io_map_pkg::KIND_8PT, 1'b1, 1'b0, 1'b1);
        wr(slave_io_map_pkg::ADDR_CTRL, 32'h3);
        rd(slave_io_map_pkg::ADDR_ACT_OUT, 32'h0);
        rd(slave_io_map_pkg::ADDR_ACT_IN, 32'h0);
        rd(slave_io_map_pkg::ADDR_ERR_OUT, 32'h0);
        rd(slave_io_map_pkg::ADDR_CTRL, 32'h1);
        settle();
        check("lamp", 1'b0, linkStatusLamp);
        apb(1'b0, 8'h60, 32'h0, 32'h0, 1'b1, 1'b1);
        apb(1'b1, slave_io_map_pkg::ADDR_IN_BASE, 32'hffff, 32'h0, 1'b0, 1'b1);
        settle();
        $display("restart and refusals done");
        end_of_test();
    end
endmodule

bind slave_io_map slave_io_map_asserts i_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .joinStrobe(joinStrobe), .joinReq(joinReq),
    .outImage(outImage), .linkStatusLamp(linkStatusLamp));
